// ===== rtl/sdct_pkg.sv
// Purpose: Shared constants, types and helpers of the SDRAM command timing device.
// Assumes: Commands, mask and write data arrive on mclk, the shared memory clock.
// Notes:   The array is a reduced model: two low row bits and four column bits per bank.
package sdct_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin widths
    localparam int ADDR_W      = 13;
    localparam int DATA_W      = 16;
    localparam int BANK_W      = 2;
    localparam int BANKS       = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Kept array geometry
    localparam int ROW_KEEP    = 2;
    localparam int COL_KEEP    = 4;
    localparam int MEM_AW      = BANK_W + ROW_KEEP + COL_KEEP;
    localparam int MEM_WORDS   = 1 << MEM_AW;

    ////////////////////////////////////////////////////////////////////////////
    // Write queue
    localparam int QUEUE_DEPTH = 8;
    localparam int QUEUE_W     = MEM_AW + DATA_W;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and cycle latencies
    localparam int CLK_PERIOD_NS     = 100;
    localparam int CKE_LATENCY_CK    = 1;
    localparam int READ_MASK_FLOAT_CK = 2;
    localparam int PIPE_STAGES       = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_REFRESH   = 4'h1;
    localparam logic [3:0] CMD_PRECHARGE = 4'h2;
    localparam logic [3:0] CMD_ACTIVATE  = 4'h3;
    localparam logic [3:0] CMD_WRITE     = 4'h4;
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_STOP      = 4'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Address fields
    localparam int AP_BIT = 10;
    localparam int BL_LSB = 0;
    localparam int BL_W   = 3;
    localparam int CL_LSB = 4;
    localparam int CL_W   = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Mode encodings and reset values
    localparam logic [BL_W-1:0] BL_CODE_1    = 3'h0;
    localparam logic [BL_W-1:0] BL_CODE_2    = 3'h1;
    localparam logic [BL_W-1:0] BL_CODE_4    = 3'h2;
    localparam logic [BL_W-1:0] BL_CODE_8    = 3'h3;
    localparam logic [CL_W-1:0] CL_CODE_2    = 3'h2;
    localparam logic [1:0]      CL2          = 2'h2;
    localparam logic [1:0]      CL3          = 2'h3;
    localparam logic [BL_W-1:0] BL_RESET     = BL_CODE_1;
    localparam logic [1:0]      CL_RESET     = CL3;
    localparam logic [4:0]      BEATS_1      = 5'h01;
    localparam logic [4:0]      BEATS_2      = 5'h02;
    localparam logic [4:0]      BEATS_4      = 5'h04;
    localparam logic [4:0]      BEATS_8      = 5'h08;
    localparam logic [4:0]      BEATS_PAGE   = 5'h10;

    typedef enum logic [1:0] {SDCT_IDLE, SDCT_READ, SDCT_WRITE} sdct_burst_t;

    typedef struct packed {
        logic [BL_W-1:0]                bl_code;
        logic [1:0]                     cl;
        logic [BANKS-1:0]               bank_open;
        logic [BANKS-1:0][ROW_KEEP-1:0] bank_row;
        sdct_burst_t                    burst;
        logic [BANK_W-1:0]              b_bank;
        logic [ROW_KEEP-1:0]            b_row;
        logic [COL_KEEP-1:0]            b_col;
        logic [4:0]                     b_left;
        logic                           b_ap;
        logic                           cke_d;
        logic                           self_ref;
        logic                           dqm_d;
        logic [PIPE_STAGES-1:0]         pv;
        logic [PIPE_STAGES-1:0][DATA_W-1:0] pd;
        logic [DATA_W-1:0]              dout;
        logic                           dout_en;
    } sdct_state_t;

    // Burst length from the mode code; unknown codes run a full page
    function automatic logic [4:0] sdct_burst_beats(input logic [BL_W-1:0] code);
        case (code)
            BL_CODE_1: sdct_burst_beats = BEATS_1;
            BL_CODE_2: sdct_burst_beats = BEATS_2;
            BL_CODE_4: sdct_burst_beats = BEATS_4;
            BL_CODE_8: sdct_burst_beats = BEATS_8;
            default:   sdct_burst_beats = BEATS_PAGE;
        endcase
    endfunction

    // Word index of a bank, kept row bits and column
    function automatic logic [MEM_AW-1:0] sdct_mem_index(input logic [BANK_W-1:0]   bank,
                                                         input logic [ROW_KEEP-1:0] row,
                                                         input logic [COL_KEEP-1:0] col);
        sdct_mem_index = {bank, row, col};
    endfunction

endpackage

// ===== rtl/sdct_stream_if.sv
// Purpose: Valid/ready word carrier between the device core and its write queue.
// Assumes: Both ends on mclk.
// Notes:   A word moves on an edge where valid and ready are both high.
`timescale 1ns/100ps
`default_nettype none
interface sdct_stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== rtl/sdct_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Read data comes straight from the storage flops, so a pop costs no cycle.
`timescale 1ns/100ps
`default_nettype none
module sdct_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    input wire logic    mclk,
    input wire logic    rst_n,
    sdct_stream_if.snk  wr_side,
    sdct_stream_if.src  rd_side
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } sdct_fifo_state_t;

    sdct_fifo_state_t st_reg;
    sdct_fifo_state_t st_next;
    logic [WIDTH-1:0] store [DEPTH];
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////////
    // Honest full and empty from the occupancy count
    assign wr_side.ready = (st_reg.cnt != CW'(DEPTH));
    assign rd_side.valid = (st_reg.cnt != '0);
    assign rd_side.data  = store[st_reg.rp];
    assign push          = wr_side.valid && wr_side.ready;
    assign pop           = rd_side.valid && rd_side.ready;

    // Pointer and count update
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wp = PW'(st_reg.wp + 1'b1);
        end
        if (pop) begin
            st_next.rp = PW'(st_reg.rp + 1'b1);
        end
        if (push && !pop) begin
            st_next.cnt = CW'(st_reg.cnt + 1'b1);
        end else if (pop && !push) begin
            st_next.cnt = CW'(st_reg.cnt - 1'b1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage needs no reset; empty slots are never read out as valid
    always_ff @(posedge mclk) begin
        if (push) begin
            store[st_reg.wp] <= wr_side.data;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/sdct_device.sv
// Purpose: Memory-side logic of a four-bank SDR SDRAM: command decode, bursts, masks,
//          clock-enable latency, self refresh and a small data array.
// Assumes: All pins are driven by the controller on mclk, so no synchronisers are needed.
// Notes:   Write beats pass an 8-word queue before reaching the array.
// Notes on behaviour
// - Column commands may come every cycle; memory accepts each one.
// - Clock-enable changes take effect one cycle later.
// - Write mask blocks the data element on the same edge.
// - Read mask floats the outputs two cycles later.
// - First write data is captured on the write command edge.
// - Precharge during a read floats outputs after CAS latency cycles.
`timescale 1ns/100ps
`default_nettype none
module sdct_device (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire logic                          cke,
    input  wire logic                          cs_n,
    input  wire logic                          ras_n,
    input  wire logic                          cas_n,
    input  wire logic                          we_n,
    input  wire logic [sdct_pkg::BANK_W-1:0]   ba,
    input  wire logic [sdct_pkg::ADDR_W-1:0]   addr,
    input  wire logic                          dqm,
    input  wire logic [sdct_pkg::DATA_W-1:0]   dq_in,
    output logic      [sdct_pkg::DATA_W-1:0]   dq_out,
    output logic                               dq_oe_n,
    output logic      [sdct_pkg::BANKS-1:0]    bank_active,
    output logic                               in_self_refresh,
    output logic                               in_power_down,
    output logic                               wq_ready
);
    import sdct_pkg::*;

    sdct_state_t       st_reg;
    sdct_state_t       st_next;
    logic [DATA_W-1:0] mem [MEM_WORDS];
    logic [3:0]        cmd;
    logic              ck_en;
    logic              start;
    logic              kill;
    logic [MEM_AW-1:0] beat_addr;
    logic              fetch_valid;
    logic [DATA_W-1:0] fetch_data;
    logic              q_valid;
    logic [QUEUE_W-1:0] q_data;
    logic              out_sel;

    sdct_stream_if #(.W(QUEUE_W)) wq_in  ();
    sdct_stream_if #(.W(QUEUE_W)) wq_out ();

    ////////////////////////////////////////////////////////////////////////////
    // Write queue between capture and array
    assign wq_in.valid = q_valid;
    assign wq_in.data  = q_data;
    // Drain pauses in self refresh; no write arrives then, so the queue never holds more than one word
    assign wq_out.ready = !st_reg.self_ref;
    assign wq_ready     = wq_in.ready;

    sdct_fifo #(
        .WIDTH (QUEUE_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_write_queue (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .wr_side (wq_in),
        .rd_side (wq_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status and data pins
    assign dq_out          = st_reg.dout;
    assign dq_oe_n         = !st_reg.dout_en;
    assign bank_active     = st_reg.bank_open;
    assign in_self_refresh = st_reg.self_ref;
    assign in_power_down   = !st_reg.cke_d && !st_reg.self_ref;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode, burst engine and output pipeline
    always_comb begin
        st_next     = st_reg;
        cmd         = {cs_n, ras_n, cas_n, we_n};
        ck_en       = st_reg.cke_d;
        start       = 1'b0;
        kill        = 1'b0;
        beat_addr   = '0;
        fetch_valid = 1'b0;
        fetch_data  = '0;
        q_valid     = 1'b0;
        q_data      = '0;
        out_sel     = (st_reg.cl == CL3);
        // Sampled now, acts from the next edge on
        st_next.cke_d = cke;
        if (st_reg.self_ref) begin
            // Leave self refresh once cke is seen high again
            if (cke) begin
                st_next.self_ref = 1'b0;
            end
        end else if (ck_en) begin
            st_next.dqm_d = dqm;
            // A column command to an open bank opens a new burst on every edge it appears
            start = ((cmd == CMD_READ) || (cmd == CMD_WRITE)) && st_reg.bank_open[ba];
            kill  = (cmd == CMD_READ) || (cmd == CMD_WRITE) || (cmd == CMD_STOP)
                 || ((cmd == CMD_PRECHARGE) && (addr[AP_BIT] || (ba == st_reg.b_bank)));
            if (start) begin
                st_next.burst  = (cmd == CMD_READ) ? SDCT_READ : SDCT_WRITE;
                st_next.b_bank = ba;
                st_next.b_row  = st_reg.bank_row[ba];
                st_next.b_col  = addr[COL_KEEP-1:0];
                st_next.b_left = sdct_burst_beats(st_reg.bl_code);
                st_next.b_ap   = addr[AP_BIT];
            end else if (kill) begin
                // No beat is fetched on this edge, so later beats never drive
                st_next.burst = SDCT_IDLE;
            end
            case (cmd)
                CMD_ACTIVATE: begin
                    st_next.bank_open[ba] = 1'b1;
                    st_next.bank_row[ba]  = addr[ROW_KEEP-1:0];
                end
                CMD_PRECHARGE: begin
                    if (addr[AP_BIT]) begin
                        st_next.bank_open = '0;
                    end else begin
                        st_next.bank_open[ba] = 1'b0;
                    end
                end
                CMD_REFRESH: begin
                    // Refresh with cke falling enters self refresh
                    if (!cke) begin
                        st_next.self_ref = 1'b1;
                        st_next.burst    = SDCT_IDLE;
                    end
                end
                CMD_LOAD_MODE: begin
                    st_next.bl_code = addr[BL_LSB +: BL_W];
                    st_next.cl      = (addr[CL_LSB +: CL_W] == CL_CODE_2) ? CL2 : CL3;
                end
                default: begin
                end
            endcase
            // One beat per enabled edge, the first on the command edge itself
            if (st_next.burst != SDCT_IDLE) begin
                beat_addr = sdct_mem_index(st_next.b_bank, st_next.b_row, st_next.b_col);
                if (st_next.burst == SDCT_READ) begin
                    fetch_valid = 1'b1;
                    fetch_data  = mem[beat_addr];
                end else if (!dqm) begin
                    q_valid = 1'b1;
                    q_data  = {beat_addr, dq_in};
                end
                if (st_next.b_left == BEATS_1) begin
                    st_next.burst = SDCT_IDLE;
                    if (st_next.b_ap) begin
                        st_next.bank_open[st_next.b_bank] = 1'b0;
                    end
                end
                st_next.b_col  = st_next.b_col + 1'b1;
                st_next.b_left = st_next.b_left - 1'b1;
            end
            // Delay line sized for CAS latency; a suspended clock freezes it
            st_next.pv[0] = fetch_valid;
            st_next.pd[0] = fetch_data;
            st_next.pv[1] = st_reg.pv[0];
            st_next.pd[1] = st_reg.pd[0];
            st_next.dout  = st_reg.pd[out_sel];
            // Mask seen one edge ago gates this load: float two edges after mask
            st_next.dout_en = st_reg.pv[out_sel] && !st_reg.dqm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.bl_code <= BL_RESET;
            st_reg.cl      <= CL_RESET;
            st_reg.burst   <= SDCT_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array write port fed by the queue; no reset, contents are undefined anyway
    always_ff @(posedge mclk) begin
        if (wq_out.valid && wq_out.ready) begin
            mem[wq_out.data[QUEUE_W-1:DATA_W]] <= wq_out.data[DATA_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ===== verif/sdct_device_sva.sv
// Purpose: Port-level timing checks of the SDRAM command timing device.
// Assumes: One mclk domain; rst_n asynchronous, active low.
// Notes:   An edge counts only when clock enable was registered high.
`timescale 1ns/100ps
`default_nettype none
module sdct_device_sva (
    input wire logic                        mclk,
    input wire logic                        rst_n,
    input wire logic                        cke,
    input wire logic                        cs_n,
    input wire logic                        ras_n,
    input wire logic                        cas_n,
    input wire logic                        we_n,
    input wire logic [sdct_pkg::BANK_W-1:0] ba,
    input wire logic [sdct_pkg::ADDR_W-1:0] addr,
    input wire logic                        dqm,
    input wire logic [sdct_pkg::DATA_W-1:0] dq_in,
    input wire logic [sdct_pkg::DATA_W-1:0] dq_out,
    input wire logic                        dq_oe_n,
    input wire logic [sdct_pkg::BANKS-1:0]  bank_active,
    input wire logic                        in_self_refresh,
    input wire logic                        in_power_down,
    input wire logic                        wq_ready
);
    import sdct_pkg::*;
    logic [3:0] cmd;
    logic       live;
    logic [4:0] since_rd;

    // Command code and whether this edge is honoured
    assign cmd  = {cs_n, ras_n, cas_n, we_n};
    assign live = !in_power_down && !in_self_refresh;

    // Active edges since the last read; saturates so long idle cannot wrap
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            since_rd <= 5'h1f;
        else if (live && cmd == CMD_READ)
            since_rd <= 5'h00;
        else if (live && since_rd != 5'h1f)
            since_rd <= since_rd + 5'h01;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    property p_cke_off;
        !cke && !in_self_refresh |=> in_power_down || in_self_refresh;
    endproperty
    a_cke_off: assert property (p_cke_off) else $error("suspend late");
    property p_cke_on;
        cke && !in_self_refresh |=> !in_power_down;
    endproperty
    a_cke_on: assert property (p_cke_on) else $error("resume late");
    property p_mask;
        dqm && live ##1 live |=> dq_oe_n;
    endproperty
    a_mask: assert property (p_mask) else $error("masked beat driven");
    property p_prech;
        cmd == CMD_PRECHARGE && addr[AP_BIT] && live ##1 live [*2] |=> dq_oe_n;
    endproperty
    a_prech: assert property (p_prech) else $error("drive after precharge");
    property p_read;
        cmd == CMD_READ && bank_active[ba] && live && !dqm ##1 (cs_n && !dqm && live) [*2]
            |-> ##[0:1] !dq_oe_n;
    endproperty
    a_read: assert property (p_read) else $error("read not answered");
    property p_since;
        !dq_oe_n |-> since_rd <= 5'h11;
    endproperty
    a_since: assert property (p_since) else $error("drive without read");
endmodule

bind sdct_device sdct_device_sva u_sva (.mclk(mclk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .bank_active(bank_active),
    .in_self_refresh(in_self_refresh), .in_power_down(in_power_down), .wq_ready(wq_ready));
`default_nettype wire

// ===== verif/sdct_ctrl_model.sv
// Purpose: Controller model driving the device pins.
// Assumes: Pins change on falling edges of mclk.
// Notes:   ROW_GAP, REF_GAP and XSR_GAP are ns limits rounded up to whole 100 ns cycles; the other gaps are fixed cycle counts.
`timescale 1ns/100ps
`default_nettype none
module sdct_ctrl_model (
    input  wire logic                   mclk,
    output logic                        cke,
    output logic                        cs_n,
    output logic                        ras_n,
    output logic                        cas_n,
    output logic                        we_n,
    output logic [sdct_pkg::BANK_W-1:0] ba,
    output logic [sdct_pkg::ADDR_W-1:0] addr,
    output logic                        dqm,
    output logic [sdct_pkg::DATA_W-1:0] dq_in
);
    import sdct_pkg::*;
    // Tenths of ns to cycles, rounded up so no limit is cut short
    function automatic int ck10(input int t);
        return (t + CLK_PERIOD_NS * 10 - 1) / (CLK_PERIOD_NS * 10);
    endfunction
    localparam int ROW_GAP  = ck10(675);
    localparam int REF_GAP  = ck10(720);
    localparam int BANK_GAP = 2;
    localparam int MODE_GAP = 2;
    localparam int WR_GAP   = 2;
    localparam int XSR_GAP  = ck10(1200);

    // Idle bus; no auto precharge writes, run far inside one refresh window
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n, dqm} = 6'h3e;
        ba = '0;
        addr = '0;
        dq_in = 16'h5a5a;
    end

    // One command per falling edge; data lines toggle when not carrying a write
    task automatic cmd(input logic k, input logic [3:0] c, input logic [BANK_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic m, input logic [DATA_W-1:0] d);
        @(negedge mclk);
        cke = k;
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        dqm = m;
        dq_in = (c == CMD_WRITE) ? d : ~dq_in;
    endtask
    task automatic nop(input int n);
        repeat (n) cmd(1'b1, 4'hf, '0, '0, 1'b0, '0);
    endtask
    // Close every bank, then load the mode word
    task automatic remode(input logic [ADDR_W-1:0] m);
        cmd(1'b1, CMD_PRECHARGE, '0, 13'h0400, 1'b0, '0);
        nop(ROW_GAP);
        cmd(1'b1, CMD_LOAD_MODE, '0, m, 1'b0, '0);
        nop(MODE_GAP);
    endtask
    task automatic init(input logic [ADDR_W-1:0] m);
        nop(2);
        remode(m);
        repeat (2) begin
            cmd(1'b1, CMD_REFRESH, '0, '0, 1'b0, '0);
            nop(REF_GAP);
        end
    endtask
    task automatic open(input logic [BANK_W-1:0] b);
        cmd(1'b1, CMD_ACTIVATE, b, '0, 1'b0, '0);
        nop(BANK_GAP);
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_sdct_device.sv
// Purpose: Self-checking bench for the SDRAM command timing device.
// Assumes: Controller model changes pins on falling edges.
// Notes:   The write queue drains every cycle outside self refresh, so the pins alone cannot fill it.
`timescale 1ns/100ps
`default_nettype none
module tb_sdct_device;
    import sdct_pkg::*;
    logic              mclk, rst_n, cke, cs_n, ras_n, cas_n, we_n, dqm;
    logic              dq_oe_n, in_self_refresh, in_power_down, wq_ready;
    logic [BANK_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_in, dq_out;
    logic [BANKS-1:0]  bank_active;
    int                bad_count, tests_run;

    sdct_device uut (.mclk(mclk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .bank_active(bank_active),
        .in_self_refresh(in_self_refresh), .in_power_down(in_power_down), .wq_ready(wq_ready));
    sdct_ctrl_model ctl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));

    // Fixed period; the rate never changes during an access
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results;
        if (bad_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Follow a read issued on the coming edge; flt bit i marks a floated beat
    task automatic beats(input int cl, input int n, input logic [DATA_W-1:0] base,
                         input logic [3:0] flt);
        @(negedge mclk);
        repeat (cl) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            chk("enable_n", {15'h0, flt[i]}, {15'h0, dq_oe_n});
            if (!flt[i])
                chk("read data", base + 16'(i), dq_out);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Back-to-back writes, a masked rewrite, then back-to-back reads
    task automatic t_write_read;
        ctl.open(2'h0);
        for (int i = 0; i < 4; i++)
            ctl.cmd(1'b1, CMD_WRITE, 2'h0, 13'(i), 1'b0, 16'h1a00 + 16'(i));
        ctl.cmd(1'b1, CMD_WRITE, 2'h0, 13'h0002, 1'b1, 16'hdead);
        ctl.nop(ctl.WR_GAP);
        fork
            begin
                for (int i = 0; i < 4; i++)
                    ctl.cmd(1'b1, CMD_READ, 2'h0, 13'(i), 1'b0, '0);
                ctl.nop(1);
            end
            beats(3, 4, 16'h1a00, 4'h0);
        join
    endtask
    // Mask two edges into a four-beat read floats only the second beat
    task automatic t_mask_read;
        ctl.remode(13'h0032);
        ctl.open(2'h0);
        fork
            begin
                ctl.cmd(1'b1, CMD_READ, 2'h0, '0, 1'b0, '0);
                ctl.cmd(1'b1, 4'hf, '0, '0, 1'b0, '0);
                ctl.cmd(1'b1, 4'hf, '0, '0, 1'b1, '0);
                ctl.nop(1);
            end
            beats(3, 4, 16'h1a00, 4'h2);
        join
    endtask
    // Precharge right after a read, at both CAS latencies
    task automatic t_prech_read;
        for (int cl = 2; cl < 4; cl++) begin
            ctl.remode(cl == 2 ? 13'h0022 : 13'h0032);
            ctl.open(2'h0);
            fork
                begin
                    ctl.cmd(1'b1, CMD_READ, 2'h0, '0, 1'b0, '0);
                    ctl.cmd(1'b1, CMD_PRECHARGE, 2'h0, 13'h0400, 1'b0, '0);
                    ctl.nop(1);
                end
                beats(cl, 4, 16'h1a00, 4'he);
            join
        end
    endtask
    // One low clock-enable edge swallows the read on the following edge
    task automatic t_suspend;
        ctl.remode(13'h0030);
        ctl.open(2'h0);
        ctl.cmd(1'b0, 4'hf, '0, '0, 1'b0, '0);
        ctl.cmd(1'b1, CMD_READ, 2'h0, 13'h0001, 1'b0, '0);
        chk("power down", 16'h1, {15'h0, in_power_down});
        ctl.nop(1);
        chk("power down", 16'h0, {15'h0, in_power_down});
        repeat (5) begin
            @(negedge mclk);
            chk("enable_n", 16'h1, {15'h0, dq_oe_n});
        end
        fork
            begin
                ctl.cmd(1'b1, CMD_READ, 2'h0, 13'h0001, 1'b0, '0);
                ctl.nop(1);
            end
            beats(3, 1, 16'h1a01, 4'h0);
        join
    endtask
    // Another bank, self refresh entry and exit; the stored word survives it
    task automatic t_self_ref;
        ctl.open(2'h3);
        chk("open banks", 16'h9, {12'h0, bank_active});
        ctl.cmd(1'b1, CMD_WRITE, 2'h3, 13'h0005, 1'b0, 16'h3c3c);
        chk("queue ready", 16'h1, {15'h0, wq_ready});
        ctl.nop(ctl.WR_GAP);
        ctl.remode(13'h0030);
        chk("open banks", 16'h0, {12'h0, bank_active});
        ctl.cmd(1'b0, CMD_REFRESH, '0, '0, 1'b0, '0);
        ctl.cmd(1'b0, 4'hf, '0, '0, 1'b0, '0);
        chk("self refresh", 16'h1, {15'h0, in_self_refresh});
        chk("power down", 16'h0, {15'h0, in_power_down});
        ctl.nop(ctl.XSR_GAP + 1);
        chk("self refresh", 16'h0, {15'h0, in_self_refresh});
        ctl.open(2'h3);
        chk("open banks", 16'h8, {12'h0, bank_active});
        fork
            begin
                ctl.cmd(1'b1, CMD_READ, 2'h3, 13'h0005, 1'b0, '0);
                ctl.nop(1);
            end
            beats(3, 1, 16'h3c3c, 4'h0);
        join
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, bring-up, scenarios
    initial begin
        bad_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        ctl.init(13'h0030);
        t_write_read();
        t_mask_read();
        t_prech_read();
        t_suspend();
        t_self_ref();
        results();
    end
    // Watchdog, well beyond the fewer than 150 cycles the scenarios need
    initial begin
        repeat (3000) @(posedge mclk);
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
